// file: design/tab_timer_top.sv
/*
 timer block: two 8-bit auto-reload timers, the 16-bit aux timer with
 bit-rate generator, capture and reload, and the register port.
 assumes pins are synchronous to clk and registers sit at sfr offsets.

*/
`timescale 1ns/10ps
module tab_timer_top (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_rd,
   output logic      [7:0] sfr_rdata,
   // pins
   input  wire logic       aux_external_count_pin,
   input  wire logic       aux_capture_trigger_pin,
   // interrupt requests
   output logic            irq_first_timer,
   output logic            irq_second_timer,
   output logic            irq_aux_timer,
   // uart bit clocks
   output logic            rx_bit_clock,
   output logic            tx_bit_clock
);
   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a);
      return sfr_wr && (sfr_addr == a);
   endfunction

   logic wr_basic;
   logic wr_aux;
   assign wr_basic = hit(tab_pkg::ADDR_BASIC_CTRL);
   assign wr_aux   = hit(tab_pkg::ADDR_AUX_CTRL);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic [7:0]  basic_timer_control;
   logic [7:0]  aux_timer_control;
   logic        half_en;
   logic        count_pin_q;
   logic        trig_pin_q;
   logic [7:0]  next_basic;
   logic [7:0]  next_aux;
   logic        next_half_en;
   logic [7:0]  next_rdata;
   logic        next_irq0;
   logic        next_irq1;
   logic        next_irq2;
   logic        next_rx_clk;
   logic        next_tx_clk;

   // -----------------------------------------------------------------
   // aliases of control fields
   // -----------------------------------------------------------------
   logic run0;
   logic run1;
   logic receive_clock_select;
   logic transmit_clock_select;
   logic aux_external_enable;
   logic aux_timer_run;
   logic aux_counter_timer_select;
   logic aux_capture_reload_select;
   logic baud_mode;
   assign run0                      = basic_timer_control[tab_pkg::BC_RUN0];
   assign run1                      = basic_timer_control[tab_pkg::BC_RUN1];
   assign receive_clock_select      = aux_timer_control[tab_pkg::AC_RCLK];
   assign transmit_clock_select     = aux_timer_control[tab_pkg::AC_TRANSMIT_CLOCK_SELECT];
   assign aux_external_enable       = aux_timer_control[tab_pkg::AC_EXEN];
   assign aux_timer_run             = aux_timer_control[tab_pkg::AC_RUN];
   assign aux_counter_timer_select  = aux_timer_control[tab_pkg::AC_CT];
   assign aux_capture_reload_select = aux_timer_control[tab_pkg::AC_CPRL];
   assign baud_mode = receive_clock_select | transmit_clock_select;

   // -----------------------------------------------------------------
   // pin edges
   // -----------------------------------------------------------------
   logic count_fall;
   logic trig_fall;
   assign count_fall = count_pin_q & ~aux_external_count_pin;
   assign trig_fall  = trig_pin_q & ~aux_capture_trigger_pin;

   // -----------------------------------------------------------------
   // aux timer tick and trigger
   // -----------------------------------------------------------------
   logic aux_tick;
   logic aux_trigger;
   // the external pin overrides the half-rate clock even in bit-rate mode
   assign aux_tick = aux_timer_run &&
                     (aux_counter_timer_select ? count_fall : half_en);
   // edges on the trigger pin are ignored while generating bit clocks
   assign aux_trigger = trig_fall && aux_external_enable && !baud_mode;

   // -----------------------------------------------------------------
   // counters
   // -----------------------------------------------------------------
   logic [7:0]  first_timer_count_low;
   logic [7:0]  first_timer_reload_high;
   logic [7:0]  second_timer_count_low;
   logic [7:0]  second_timer_reload_high;
   logic [15:0] aux_count;
   logic [15:0] aux_reload;
   logic        ovf0;
   logic        ovf1;
   logic        ovf2;

   // the low byte must be preset by software before the run bit is set
   tab_reload8 u_first (
      .clk       (clk),
      .rst_n     (rst_n),
      .tick      (run0),
      .wr_count  (hit(tab_pkg::ADDR_FIRST_LOW)),
      .wr_reload (hit(tab_pkg::ADDR_FIRST_HIGH)),
      .wdata     (sfr_wdata),
      .count     (first_timer_count_low),
      .reload    (first_timer_reload_high),
      .ovf       (ovf0)
   );

   tab_reload8 u_second (
      .clk       (clk),
      .rst_n     (rst_n),
      .tick      (run1),
      .wr_count  (hit(tab_pkg::ADDR_SECOND_LOW)),
      .wr_reload (hit(tab_pkg::ADDR_SECOND_HIGH)),
      .wdata     (sfr_wdata),
      .count     (second_timer_count_low),
      .reload    (second_timer_reload_high),
      .ovf       (ovf1)
   );

   tab_aux16 u_aux (
      .clk           (clk),
      .rst_n         (rst_n),
      .tick          (aux_tick),
      .trigger       (aux_trigger),
      .capture_sel   (aux_capture_reload_select),
      .reload_on_ovf (baud_mode || !aux_capture_reload_select),
      .wr_cnt_lo     (hit(tab_pkg::ADDR_AUX_CNT_LOW)),
      .wr_cnt_hi     (hit(tab_pkg::ADDR_AUX_CNT_HIGH)),
      .wr_cap_lo     (hit(tab_pkg::ADDR_AUX_CAP_LOW)),
      .wr_cap_hi     (hit(tab_pkg::ADDR_AUX_CAP_HIGH)),
      .wdata         (sfr_wdata),
      .count         (aux_count),
      .capture       (aux_reload),
      .ovf           (ovf2)
   );

   // -----------------------------------------------------------------
   // next values
   // -----------------------------------------------------------------
   always_comb begin
      next_half_en = !half_en;
      // software writes first, hardware sets win over a same-cycle clear
      next_basic = wr_basic ? sfr_wdata : basic_timer_control;
      next_basic[7] = 1'b0;
      if (ovf0) next_basic[tab_pkg::BC_TF0] = 1'b1;
      if (ovf1) next_basic[tab_pkg::BC_TF1] = 1'b1;
      next_aux = wr_aux ? sfr_wdata : aux_timer_control;
      if (ovf2) next_aux[tab_pkg::AC_TF2] = 1'b1;
      if (aux_trigger) next_aux[tab_pkg::AC_AUX_EXTERNAL_EVENT_FLAG] = 1'b1;

      next_irq0 = next_basic[tab_pkg::BC_TF0] && next_basic[tab_pkg::BC_IE0];
      next_irq1 = next_basic[tab_pkg::BC_TF1] && next_basic[tab_pkg::BC_IE1];
      next_irq2 = (next_aux[tab_pkg::AC_TF2] || next_aux[tab_pkg::AC_AUX_EXTERNAL_EVENT_FLAG]) &&
                  next_basic[tab_pkg::BC_IE2] &&
                  !(next_aux[tab_pkg::AC_RCLK] || next_aux[tab_pkg::AC_TRANSMIT_CLOCK_SELECT]);

      // one-cycle bit clock pulses, second timer when not selected
      next_rx_clk = receive_clock_select ? ovf2 : ovf1;
      next_tx_clk = transmit_clock_select ? ovf2 : ovf1;

      next_rdata = sfr_rdata;
      if (sfr_rd) begin
         unique case (sfr_addr)
            tab_pkg::ADDR_BASIC_CTRL:   next_rdata = basic_timer_control;
            tab_pkg::ADDR_FIRST_LOW:    next_rdata = first_timer_count_low;
            tab_pkg::ADDR_SECOND_LOW:   next_rdata = second_timer_count_low;
            tab_pkg::ADDR_FIRST_HIGH:   next_rdata = first_timer_reload_high;
            tab_pkg::ADDR_SECOND_HIGH:  next_rdata = second_timer_reload_high;
            tab_pkg::ADDR_AUX_CTRL:     next_rdata = aux_timer_control;
            tab_pkg::ADDR_AUX_CAP_LOW:  next_rdata = aux_reload[7:0];
            tab_pkg::ADDR_AUX_CAP_HIGH: next_rdata = aux_reload[15:8];
            tab_pkg::ADDR_AUX_CNT_LOW:  next_rdata = aux_count[7:0];
            tab_pkg::ADDR_AUX_CNT_HIGH: next_rdata = aux_count[15:8];
            default:                    next_rdata = tab_pkg::RST_BYTE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         basic_timer_control <= tab_pkg::RST_BYTE;
         aux_timer_control   <= tab_pkg::RST_BYTE;
         half_en             <= 1'b0;
         count_pin_q         <= 1'b0;
         trig_pin_q          <= 1'b0;
         sfr_rdata           <= tab_pkg::RST_BYTE;
         irq_first_timer     <= 1'b0;
         irq_second_timer    <= 1'b0;
         irq_aux_timer       <= 1'b0;
         rx_bit_clock        <= 1'b0;
         tx_bit_clock        <= 1'b0;
      end else begin
         basic_timer_control <= next_basic;
         aux_timer_control   <= next_aux;
         half_en             <= next_half_en;
         count_pin_q         <= aux_external_count_pin;
         trig_pin_q          <= aux_capture_trigger_pin;
         sfr_rdata           <= next_rdata;
         irq_first_timer     <= next_irq0;
         irq_second_timer    <= next_irq1;
         irq_aux_timer       <= next_irq2;
         rx_bit_clock        <= next_rx_clk;
         tx_bit_clock        <= next_tx_clk;
      end
   end
endmodule

// file: design/tab_pkg.sv
/*
 holds the register map, field positions, reset values and timing counts
 of the timer block. assumes a 25 MHz system clock and 8-bit register data.
*/
package tab_pkg;
   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_BASIC_CTRL   = 8'h88;
   localparam logic [7:0] ADDR_FIRST_LOW    = 8'h8a;
   localparam logic [7:0] ADDR_SECOND_LOW   = 8'h8b;
   localparam logic [7:0] ADDR_FIRST_HIGH   = 8'h8c;
   localparam logic [7:0] ADDR_SECOND_HIGH  = 8'h8d;
   localparam logic [7:0] ADDR_AUX_CTRL     = 8'hc8;
   localparam logic [7:0] ADDR_AUX_CAP_LOW  = 8'hca;
   localparam logic [7:0] ADDR_AUX_CAP_HIGH = 8'hcb;
   localparam logic [7:0] ADDR_AUX_CNT_LOW  = 8'hcc;
   localparam logic [7:0] ADDR_AUX_CNT_HIGH = 8'hcd;

   // -----------------------------------------------------------------
   // basic timer control fields
   // -----------------------------------------------------------------
   localparam int BC_RUN0 = 0;
   localparam int BC_RUN1 = 1;
   localparam int BC_IE0  = 2;
   localparam int BC_IE1  = 3;
   localparam int BC_IE2  = 4;
   localparam int BC_TF0  = 5;
   localparam int BC_TF1  = 6;

   // -----------------------------------------------------------------
   // aux timer control fields
   // -----------------------------------------------------------------
   localparam int AC_TF2   = 7;
   localparam int AC_AUX_EXTERNAL_EVENT_FLAG  = 6;
   localparam int AC_RCLK  = 5;
   localparam int AC_TRANSMIT_CLOCK_SELECT  = 4;
   localparam int AC_EXEN  = 3;
   localparam int AC_RUN   = 2;
   localparam int AC_CT    = 1;
   localparam int AC_CPRL  = 0;

   // -----------------------------------------------------------------
   // reset values and timing
   // -----------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE      = 8'h00;
   localparam logic [15:0] RST_WORD      = 16'h0000;
   localparam logic [7:0]  BYTE_ALL_ONES = 8'hff;
   localparam logic [15:0] WORD_ALL_ONES = 16'hffff;
   localparam int SYSTEM_CLOCK_HZ    = 25_000_000;
   localparam int AUX_DIVIDE   = 2;
   localparam int AUX_TICK_HZ  = SYSTEM_CLOCK_HZ / AUX_DIVIDE;
   localparam int AUX_WRAP     = 65536;
endpackage

// file: design/tab_reload8.sv
/*
 one 8-bit auto-reload counter: low byte counts, high byte holds reload.
 assumes tick is a level count enable (the top ties it to the run bit) and writes come from the register port.
*/
`timescale 1ns/10ps
module tab_reload8 (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // count enable
   input  wire logic       tick,
   // register writes
   input  wire logic       wr_count,
   input  wire logic       wr_reload,
   input  wire logic [7:0] wdata,
   // state
   output logic      [7:0] count,
   output logic      [7:0] reload,
   output logic            ovf
);
   logic [7:0] next_count;
   logic [7:0] next_reload;

   assign ovf = tick && !wr_count && (count == tab_pkg::BYTE_ALL_ONES);

   always_comb begin
      next_count  = count;
      next_reload = reload;
      if (wr_reload) begin
         next_reload = wdata;
      end
      if (wr_count) begin
         next_count = wdata;
      end else if (ovf) begin
         next_count = reload;
      end else if (tick) begin
         next_count = count + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count  <= tab_pkg::RST_BYTE;
         reload <= tab_pkg::RST_BYTE;
      end else begin
         count  <= next_count;
         reload <= next_reload;
      end
   end
endmodule

// file: design/tab_aux16.sv
/*
 the 16-bit auxiliary counter with its capture/reload word.
 assumes tick and trigger are one-cycle enables from the control logic.
*/
`timescale 1ns/10ps
module tab_aux16 (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // events and mode
   input  wire logic        tick,
   input  wire logic        trigger,
   input  wire logic        capture_sel,
   input  wire logic        reload_on_ovf,
   // register writes
   input  wire logic        wr_cnt_lo,
   input  wire logic        wr_cnt_hi,
   input  wire logic        wr_cap_lo,
   input  wire logic        wr_cap_hi,
   input  wire logic [7:0]  wdata,
   // state
   output logic      [15:0] count,
   output logic      [15:0] capture,
   output logic             ovf
);
   logic [15:0] next_count;
   logic [15:0] next_capture;

   assign ovf = tick && (count == tab_pkg::WORD_ALL_ONES);

   always_comb begin
      next_count   = count;
      next_capture = capture;
      if (ovf) begin
         // period is AUX_WRAP minus the reload word, or AUX_WRAP when reload_on_ovf is low and RST_WORD is loaded
         next_count = reload_on_ovf ? capture : tab_pkg::RST_WORD;
      end else if (tick) begin
         next_count = count + 16'h0001;
      end
      if (trigger) begin
         if (capture_sel) begin
            next_capture = count;
         end else begin
            next_count = capture;
         end
      end
      if (wr_cnt_lo) next_count[7:0] = wdata;
      if (wr_cnt_hi) next_count[15:8] = wdata;
      if (wr_cap_lo) next_capture[7:0] = wdata;
      if (wr_cap_hi) next_capture[15:8] = wdata;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count   <= tab_pkg::RST_WORD;
         capture <= tab_pkg::RST_WORD;
      end else begin
         count   <= next_count;
         capture <= next_capture;
      end
   end
endmodule

// file: dv/tab_timer_properties.sv
/*
 checker for the timer block, watching only the top module's ports.
 assumes software changes control bits only through register writes.
*/
`timescale 1ns/10ps
module tab_timer_properties (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   // pins
   input wire logic       aux_external_count_pin,
   input wire logic       aux_capture_trigger_pin,
   // requests and bit clocks
   input wire logic       irq_first_timer,
   input wire logic       irq_second_timer,
   input wire logic       irq_aux_timer,
   input wire logic       rx_bit_clock,
   input wire logic       tx_bit_clock
);
   // -----------------------------------------------------------------
   // shadow of the control bits, kept from the writes
   // -----------------------------------------------------------------
   logic [7:0]  basic_q, aux_q, th1_q;
   logic [15:0] cap_q;
   logic [1:0]  rx_cnt, tx_cnt, armed;
   logic [17:0] gap;
   logic        wr_ctrl, mapped, rx_idle, tx_idle, ie0, ie1, sel_any;
   int          rx_period;

   assign wr_ctrl = sfr_wr && (sfr_addr == tab_pkg::ADDR_BASIC_CTRL
                    || sfr_addr == tab_pkg::ADDR_AUX_CTRL);
   assign mapped = sfr_addr inside {8'h88, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
                                    8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd};
   assign ie0 = basic_q[tab_pkg::BC_IE0];
   assign ie1 = basic_q[tab_pkg::BC_IE1];
   assign sel_any = aux_q[tab_pkg::AC_RCLK] | aux_q[tab_pkg::AC_TRANSMIT_CLOCK_SELECT];
   assign rx_idle = aux_q[tab_pkg::AC_RCLK] ? !aux_q[tab_pkg::AC_RUN] : !basic_q[tab_pkg::BC_RUN1];
   assign tx_idle = aux_q[tab_pkg::AC_TRANSMIT_CLOCK_SELECT] ? !aux_q[tab_pkg::AC_RUN] : !basic_q[tab_pkg::BC_RUN1];
   assign rx_period = aux_q[tab_pkg::AC_RCLK] ?
                      tab_pkg::AUX_DIVIDE * (tab_pkg::AUX_WRAP - int'(cap_q)) : 256 - int'(th1_q);

   // two pulses after any write, so a period begun under the old setup is skipped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         basic_q <= 8'h00;
         aux_q   <= 8'h00;
         th1_q   <= 8'h00;
         cap_q   <= 16'h0000;
         rx_cnt  <= 2'h0;
         tx_cnt  <= 2'h0;
         armed   <= 2'h0;
         gap     <= 18'h00000;
      end else begin
         if (sfr_wr && sfr_addr == tab_pkg::ADDR_BASIC_CTRL) basic_q <= sfr_wdata;
         if (sfr_wr && sfr_addr == tab_pkg::ADDR_AUX_CTRL) aux_q <= sfr_wdata;
         if (sfr_wr && sfr_addr == tab_pkg::ADDR_SECOND_HIGH) th1_q <= sfr_wdata;
         if (sfr_wr && sfr_addr == tab_pkg::ADDR_AUX_CAP_LOW) cap_q[7:0] <= sfr_wdata;
         if (sfr_wr && sfr_addr == tab_pkg::ADDR_AUX_CAP_HIGH) cap_q[15:8] <= sfr_wdata;
         rx_cnt <= (wr_ctrl || !rx_idle) ? 2'h0 : rx_cnt + {1'b0, rx_cnt != 2'h3};
         tx_cnt <= (wr_ctrl || !tx_idle) ? 2'h0 : tx_cnt + {1'b0, tx_cnt != 2'h3};
         gap    <= rx_bit_clock ? 18'h00001 : gap + 18'h00001;
         armed  <= sfr_wr ? 2'h0 : armed + {1'b0, rx_bit_clock && armed != 2'h2};
      end
   end

   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
      sfr_rd && !mapped |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
   a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved without a read");
   a_reset_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> !(irq_first_timer | irq_second_timer | irq_aux_timer
      | rx_bit_clock | tx_bit_clock) && sfr_rdata == 8'h00) else $error("outputs busy at reset");
   a_aux_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
      sel_any && $past(sel_any) |-> !irq_aux_timer) else $error("aux irq in bit-rate mode");
   a_first_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
      !ie0 && !$past(ie0) |-> !irq_first_timer) else $error("first irq while disabled");
   a_second_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
      !ie1 && !$past(ie1) |-> !irq_second_timer) else $error("second irq while disabled");
   a_rx_source_idle: assert property (@(posedge clk) disable iff (!rst_n)
      rx_cnt == 2'h3 |-> !rx_bit_clock) else $error("rx clock from a stopped source");
   a_tx_source_idle: assert property (@(posedge clk) disable iff (!rst_n)
      tx_cnt == 2'h3 |-> !tx_bit_clock) else $error("tx clock from a stopped source");
   a_rx_period_exact: assert property (@(posedge clk) disable iff (!rst_n)
      rx_bit_clock && armed == 2'h2 && !(aux_q[tab_pkg::AC_RCLK] && aux_q[tab_pkg::AC_CT])
      |-> int'(gap) == rx_period) else $error("rx clock period wrong");
endmodule

bind tab_timer_top tab_timer_properties u_tab_timer_properties (
   .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
   .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .aux_external_count_pin(aux_external_count_pin),
   .aux_capture_trigger_pin(aux_capture_trigger_pin), .irq_first_timer(irq_first_timer),
   .irq_second_timer(irq_second_timer), .irq_aux_timer(irq_aux_timer),
   .rx_bit_clock(rx_bit_clock), .tx_bit_clock(tx_bit_clock));

// file: dv/tab_timer_top_tb.sv
/*
 self-checking bench for the timer block: register calls and pin edges.
 assumes the checker is bound in from its own file.
*/
`timescale 1ns/10ps
module tab_timer_top_tb;
   // -----------------------------------------------------------------
   // signals and tasks
   // -----------------------------------------------------------------
   logic       clk, rst_n, sfr_wr, sfr_rd, cnt_pin, trg_pin;
   logic       irq_first_timer, irq_second_timer, irq_aux_timer, rx_bit_clock, tx_bit_clock;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [2:0] irqs;
   int         miscompares, checked, rx_n, tx_n, rx0, tx0;

   assign irqs = {irq_aux_timer, irq_second_timer, irq_first_timer};

   tab_timer_top u_tab_timer_top (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .aux_external_count_pin(cnt_pin), .aux_capture_trigger_pin(trg_pin),
      .irq_first_timer(irq_first_timer), .irq_second_timer(irq_second_timer),
      .irq_aux_timer(irq_aux_timer), .rx_bit_clock(rx_bit_clock), .tx_bit_clock(tx_bit_clock));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // pulses are counted at the rising edge, windows are opened at the falling one
   always @(posedge clk) begin
      rx_n += int'(rx_bit_clock);
      tx_n += int'(tx_bit_clock);
   end

   task finish_test;
      $display("checked %0d, miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask

   task rdc(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      chk(sfr_rdata, exp);
   endtask

   // a missing request ends the run rather than hanging it
   task wait_irq(input int sel, input int n);
      int i;
      for (i = 0; i < n && irqs[sel] !== 1'b1; i++) @(negedge clk);
      if (i == n) begin
         miscompares++;
         finish_test();
      end
   endtask

   task win(input int n);
      idle(40);
      rx0 = rx_n;
      tx0 = tx_n;
      idle(n);
   endtask

   task trig;
      @(negedge clk);
      trg_pin = 1'b0;
      idle(3);
      trg_pin = 1'b1;
      idle(3);
   endtask

   // -----------------------------------------------------------------
   // sequence
   // -----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      cnt_pin = 1'b1;
      trg_pin = 1'b1;
      idle(3);
      rst_n = 1'b1;
      rdc(tab_pkg::ADDR_AUX_CTRL, tab_pkg::RST_BYTE);
      rdc(tab_pkg::ADDR_BASIC_CTRL, tab_pkg::RST_BYTE);
      wr(8'h99, 8'h5a);
      rdc(8'h99, 8'h00);
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h30);
      rdc(tab_pkg::ADDR_AUX_CTRL, 8'h30);
      // first timer: preset just below rollover, so the request comes at once
      wr(tab_pkg::ADDR_FIRST_HIGH, 8'h80);
      wr(tab_pkg::ADDR_FIRST_LOW, 8'hfe);
      wr(tab_pkg::ADDR_BASIC_CTRL, 8'h05);
      wait_irq(0, 6);
      rdc(tab_pkg::ADDR_BASIC_CTRL, 8'h25);
      rdc(tab_pkg::ADDR_FIRST_HIGH, 8'h80);
      wr(tab_pkg::ADDR_BASIC_CTRL, 8'h04);
      idle(3);
      chk({7'h00, irq_first_timer}, 8'h00);
      // second timer drives both bit clocks
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h00);
      wr(tab_pkg::ADDR_SECOND_HIGH, 8'hf0);
      wr(tab_pkg::ADDR_SECOND_LOW, 8'hf0);
      wr(tab_pkg::ADDR_BASIC_CTRL, 8'h0a);
      win(160);
      chk(8'(rx_n - rx0), 8'h0a);
      chk(8'(tx_n - tx0), 8'h0a);
      chk({7'h00, irq_second_timer}, 8'h01);
      rdc(tab_pkg::ADDR_BASIC_CTRL, 8'h4a);
      // aux timer as bit-rate source, receive then transmit
      wr(tab_pkg::ADDR_AUX_CAP_LOW, 8'hf0);
      wr(tab_pkg::ADDR_AUX_CAP_HIGH, 8'hff);
      wr(tab_pkg::ADDR_AUX_CNT_LOW, 8'hf0);
      wr(tab_pkg::ADDR_AUX_CNT_HIGH, 8'hff);
      wr(tab_pkg::ADDR_BASIC_CTRL, 8'h1a);
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h24);
      win(320);
      chk(8'(rx_n - rx0), 8'h0a);
      chk(8'(tx_n - tx0), 8'h14);
      chk({7'h00, irq_aux_timer}, 8'h00);
      rdc(tab_pkg::ADDR_AUX_CTRL, 8'ha4);
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h14);
      win(320);
      chk(8'(rx_n - rx0), 8'h14);
      chk(8'(tx_n - tx0), 8'h0a);
      // external pin: sixteen falling edges per overflow
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h16);
      wr(tab_pkg::ADDR_AUX_CNT_LOW, 8'hf0);
      wr(tab_pkg::ADDR_AUX_CNT_HIGH, 8'hff);
      tx0 = tx_n;
      for (int i = 0; i < 96; i++) begin
         @(negedge clk);
         cnt_pin = ~cnt_pin;
      end
      idle(4);
      chk(8'(tx_n - tx0), 8'h03);
      // aux timer outside bit-rate mode: reload on overflow and request
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h00);
      wr(tab_pkg::ADDR_AUX_CAP_LOW, 8'h00);
      wr(tab_pkg::ADDR_AUX_CAP_HIGH, 8'hff);
      wr(tab_pkg::ADDR_AUX_CNT_LOW, 8'hfc);
      wr(tab_pkg::ADDR_AUX_CNT_HIGH, 8'hff);
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h04);
      wait_irq(2, 20);
      rdc(tab_pkg::ADDR_AUX_CTRL, 8'h84);
      rdc(tab_pkg::ADDR_AUX_CNT_HIGH, 8'hff);
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h00);
      idle(3);
      chk({7'h00, irq_aux_timer}, 8'h00);
      // trigger pin: capture, reload, then ignored in bit-rate mode
      wr(tab_pkg::ADDR_AUX_CNT_LOW, 8'h34);
      wr(tab_pkg::ADDR_AUX_CNT_HIGH, 8'h12);
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h09);
      trig();
      rdc(tab_pkg::ADDR_AUX_CAP_LOW, 8'h34);
      rdc(tab_pkg::ADDR_AUX_CAP_HIGH, 8'h12);
      rdc(tab_pkg::ADDR_AUX_CTRL, 8'h49);
      chk({7'h00, irq_aux_timer}, 8'h01);
      wr(tab_pkg::ADDR_AUX_CNT_HIGH, 8'h00);
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h08);
      trig();
      rdc(tab_pkg::ADDR_AUX_CNT_HIGH, 8'h12);
      wr(tab_pkg::ADDR_AUX_CNT_HIGH, 8'h00);
      wr(tab_pkg::ADDR_AUX_CTRL, 8'h28);
      trig();
      rdc(tab_pkg::ADDR_AUX_CTRL, 8'h28);
      rdc(tab_pkg::ADDR_AUX_CNT_HIGH, 8'h00);
      finish_test();
   end
endmodule
